// [logic/csp_ctrl.sv]
// crosspoint programming controller, the far end of the link
// assumes: APB master on pclk; sclk derived here by a divider
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module csp_ctrl import csp_pkg::*; #(
  parameter int HALF = HALF_DEF
) (
  // clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // apb slave
  input  logic [7:0]  paddr,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // link to the crosspoint
  csp_link_if.ctrl    link
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum {ST_IDLE, ST_SEL, ST_HIGH, ST_LOW, ST_CSH,
                ST_LAST, ST_END, ST_CFG} csp_state_t;

  typedef struct packed {
    csp_state_t            st;
    logic [7:0]            div;
    logic [CNT_W-1:0]      idx;
    logic                  mode;
    logic                  cfg_req;
    logic [FRAME_BITS-1:0] data;
    logic [FRAME_BITS-1:0] rx;
    logic [1:0]            dsync;
    logic                  sclk;
    logic                  cs_n;
    logic                  din;
    logic                  cfg;
    logic                  rst;
    logic                  bc;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } csp_ctrl_t;

  csp_ctrl_t r_reg;
  csp_ctrl_t r_next;
  logic      tick;
  logic      last;

  // decode of mapped offsets
  function automatic logic mapped(input logic [7:0] a);
    return a == CTRL_OFS || a == DLO_OFS || a == DHI_OFS ||
           a == STAT_OFS || a == RX_OFS;
  endfunction

  // half period elapsed
  assign tick = r_reg.div == 8'(HALF - 1);
  assign last = r_reg.idx == (r_reg.mode ? WORD_LAST : FRAME_LAST);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    // dout crosses in through two flops, only stage 2 is read
    r_next.dsync = {r_reg.dsync[0], link.dout};
    r_next.div   = (r_reg.st == ST_IDLE || tick) ? 8'h00 : r_reg.div + 8'h01;
    // apb: one wait cycle, then a registered answer
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;
    if (psel && penable && !r_reg.pready) begin
      r_next.pready  = 1'b1;
      r_next.pslverr = !mapped(paddr);
      case (paddr)
        CTRL_OFS: r_next.prdata = {27'h0, r_reg.bc, r_reg.rst, r_reg.cfg_req, r_reg.mode, 1'b0};
        DLO_OFS:  r_next.prdata = r_reg.data[31:0];
        DHI_OFS:  r_next.prdata = {24'h0, r_reg.data[FRAME_BITS-1:32]};
        STAT_OFS: r_next.prdata = {31'h0, r_reg.st != ST_IDLE};
        RX_OFS:   r_next.prdata = r_reg.rx[31:0];
        default:  r_next.prdata = 32'h0;
      endcase
    end
    // writes take effect on the edge that sees pready high
    if (psel && penable && r_reg.pready && pwrite) begin
      case (paddr)
        CTRL_OFS: begin
          r_next.rst = pwdata[CB_RST];
          r_next.bc  = pwdata[CB_BC];
          // start and strobe are refused while busy
          if (r_reg.st == ST_IDLE) begin
            if (pwdata[CB_START]) begin
              r_next.st      = ST_SEL;
              r_next.mode    = pwdata[CB_MODE];
              r_next.cfg_req = pwdata[CB_CFG];
              r_next.idx     = '0;
              r_next.cs_n    = 1'b0;
            end else if (pwdata[CB_CFG]) begin
              r_next.st  = ST_CFG;
              r_next.cfg = 1'b1;
            end
          end
        end
        DLO_OFS: r_next.data[31:0] = pwdata;
        DHI_OFS: r_next.data[FRAME_BITS-1:32] = pwdata[DHI_W-1:0];
        default: ;
      endcase
    end
    // serial sequencer, advances once per half period
    if (tick) begin
      case (r_reg.st)
        ST_SEL: begin
          r_next.st   = ST_HIGH;
          r_next.sclk = 1'b1;
          r_next.din  = r_reg.data[r_reg.idx];
        end
        ST_HIGH: begin
          r_next.st   = ST_LOW;
          r_next.sclk = 1'b0;
        end
        ST_LOW: begin
          r_next.rx = {r_reg.dsync[1], r_reg.rx[FRAME_BITS-1:1]};
          if (last) begin
            r_next.st   = ST_CSH;
            r_next.cs_n = 1'b1;
          end else begin
            r_next.st   = ST_HIGH;
            r_next.idx  = r_reg.idx + CNT_W'(1);
            r_next.sclk = 1'b1;
            r_next.din  = r_reg.data[r_reg.idx + CNT_W'(1)];
          end
        end
        ST_CSH: begin
          r_next.st   = ST_LAST;
          r_next.sclk = 1'b1;
        end
        ST_LAST: begin
          r_next.st   = ST_END;
          r_next.sclk = 1'b0;
        end
        ST_END: begin
          // strobe only after every bit is in
          r_next.st  = r_reg.cfg_req ? ST_CFG : ST_IDLE;
          r_next.cfg = r_reg.cfg_req;
        end
        ST_CFG: begin
          r_next.st  = ST_IDLE;
          r_next.cfg = 1'b0;
        end
        default: r_next.st = ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg      <= '0;
      r_reg.st   <= ST_IDLE;
      r_reg.cs_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs, all from flops
  assign prdata                = r_reg.prdata;
  assign pready                = r_reg.pready;
  assign pslverr               = r_reg.pslverr;
  assign link.sclk             = r_reg.sclk;
  assign link.cs_n             = r_reg.cs_n;
  assign link.din              = r_reg.din;
  assign link.mode             = r_reg.mode;
  assign link.cfg              = r_reg.cfg;
  assign link.rst              = r_reg.rst;
  assign link.broadcast_input0 = r_reg.bc;

endmodule // csp_ctrl

// [logic/csp_device.sv]
// crosspoint serial programming port, device end
// assumes: the controller owns sclk and keeps select changes
// to the low phase of sclk; cfg held low while bits shift
//
// Contract
// - frame slot: 4-bit select lsb first, off
// - mode high selects addressed single-output update
// - addressed word is 8 bits, one slot
// - word: out 0-2, select 3-6, off 7
// - select low, sync rising, data next falling
// - controller raises select, then one rising edge
// - controller changes select only while sclk low
// - controller keeps cfg low during shifting
// - dout presents bits leaving the load register
// - chained devices take 80 clocks for two
// - cfg pulse activates shifted configuration
// - reset level: select 0, all outputs off
// - broadcast level: all on, input 0
// - reset and broadcast act without clock
// - din sampled on falling sclk edge
// - sclk and din ignored while select high
// - cfg pulse only moves fresh data
// - mode low accepts a 40-bit frame
`timescale 1ns/1ps
module csp_device import csp_pkg::*; (
  // link to the controller
  csp_link_if.dev link,
  // switch matrix drive
  output logic [NUM_OUT-1:0][SEL_W-1:0] out_sel,
  output logic [NUM_OUT-1:0]            out_off,
  // pending configuration, for observation
  output logic [FRAME_BITS-1:0]         pend_frame
);

  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  // shift side, clocked on rising sclk
  typedef struct packed {
    logic                  armed;
    logic                  seq;
    logic [CNT_W-1:0]      cnt;
    logic [FRAME_BITS-1:0] load;
    logic [WORD_BITS-1:0]  word;
  } csp_shift_t;

  // matrix side, clocked by the cfg strobe
  typedef struct packed {
    logic                            applied;
    logic [NUM_OUT-1:0][SEL_W-1:0]   sel;
    logic [NUM_OUT-1:0]              off;
  } csp_matrix_t;

  csp_shift_t  sh_reg;
  csp_shift_t  sh_next;
  csp_matrix_t mx_reg;
  csp_matrix_t mx_next;
  logic        bit_reg;
  logic        bit_v_reg;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // place one addressed word into its slot of the frame
  function automatic logic [FRAME_BITS-1:0] put_word(
    input logic [FRAME_BITS-1:0] f,
    input logic [WORD_BITS-1:0]  w
  );
    logic [FRAME_BITS-1:0] r;
    logic [WA_W-1:0]       a;
    r = f;
    a = w[WA_LSB +: WA_W];
    r[a*SLOT_W +: SEL_W]       = w[WS_LSB +: SEL_W];
    r[a*SLOT_W + SLOT_OFF]     = w[WO_BIT];
    return r;
  endfunction

  // ------------------------------------------------------------
  // falling edge capture of serial data
  // ------------------------------------------------------------
  // din is taken on the falling edge only after the rising
  // edge has armed the port; the shift itself waits for the
  // next rising edge, which is why one extra rising edge
  // is needed after the last bit
  always_ff @(negedge link.sclk or posedge link.rst) begin
    if (link.rst) begin
      bit_reg   <= 1'b0;
      bit_v_reg <= 1'b0;
    end else begin
      bit_reg   <= link.din;
      bit_v_reg <= sh_reg.armed & ~link.cs_n;
    end
  end

  // ------------------------------------------------------------
  // rising edge shift logic
  // ------------------------------------------------------------
  // next state of the shift side
  always_comb begin
    sh_next = sh_reg;
    // select high disarms; only a bit caught before it rose still commits
    if (link.cs_n) begin
      sh_next.armed = 1'b0;
    end else if (!sh_reg.armed) begin
      sh_next.armed = 1'b1;
      sh_next.seq   = ~sh_reg.seq;                // marks fresh data
      sh_next.cnt   = '0;
    end
    // commit the bit caught on the last falling edge
    if (bit_v_reg) begin
      if (!link.mode) begin
        // full frame: new bit at the top, bit 0 leaves
        sh_next.load = {bit_reg, sh_reg.load[FRAME_BITS-1:1]};
      end else begin
        // addressed word assembles apart from the frame
        sh_next.word = {bit_reg, sh_reg.word[WORD_BITS-1:1]};
        if (sh_reg.cnt == WORD_LAST) begin
          sh_next.load = put_word(sh_reg.load, sh_next.word);
        end
      end
      // saturate so long streams never wrap into a word
      if (sh_reg.cnt != '1) begin
        sh_next.cnt = sh_reg.cnt + CNT_W'(1);
      end
    end
  end

  // shift side registers; rst also clears the link state
  always_ff @(posedge link.sclk or posedge link.rst) begin
    if (link.rst) begin
      sh_reg <= '0;
    end else begin
      sh_reg <= sh_next;
    end
  end

  // ------------------------------------------------------------
  // matrix registers
  // ------------------------------------------------------------
  // copy only when a session has happened since the last
  // strobe; seq is stable here because cfg stays low while
  // bits move, so the strobe edge may sample it directly
  always_comb begin
    mx_next = mx_reg;
    if (sh_reg.seq != mx_reg.applied) begin
      mx_next.applied = sh_reg.seq;
      for (int i = 0; i < NUM_OUT; i++) begin
        mx_next.sel[i] = sh_reg.load[i*SLOT_W +: SEL_W];
        mx_next.off[i] = sh_reg.load[i*SLOT_W + SLOT_OFF];
      end
    end
  end

  // reset wins over broadcast; both are levels and need no
  // clock, while they are held any strobe is overridden
  always_ff @(posedge link.cfg or posedge link.rst or posedge link.broadcast_input0) begin
    if (link.rst) begin
      mx_reg.applied <= 1'b0;
      mx_reg.sel     <= {NUM_OUT{RST_SEL}};
      mx_reg.off     <= {NUM_OUT{RST_OFF}};
    end else if (link.broadcast_input0) begin
      // applied is left alone so a later strobe still needs fresh data
      mx_reg.sel     <= {NUM_OUT{BC_SEL}};
      mx_reg.off     <= {NUM_OUT{BC_OFF}};
    end else begin
      mx_reg <= mx_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // all straight from flip-flops
  assign out_sel    = mx_reg.sel;
  assign out_off    = mx_reg.off;
  assign pend_frame = sh_reg.load;
  // bit 0 of the load register is the next bit to leave;
  // addressed words never shift it, so chains need mode low
  assign link.dout  = sh_reg.load[0];

endmodule // csp_device

// [pkg/csp_link_if.sv]
// serial programming link between controller and crosspoint
// assumes: testbench connects both ends of link and drives the signals of link_b directly
`timescale 1ns/1ps
interface csp_link_if;
  logic sclk;             // serial clock, made by controller
  logic cs_n;             // select, active low
  logic din;              // controller to device data
  logic dout;             // device shift output, chain data
  logic mode;             // 1 addressed word, 0 full frame
  logic cfg;              // configure strobe, active high
  logic rst;              // level reset of the matrix
  logic broadcast_input0; // level, all outputs on input 0

  // controller end
  modport ctrl (
    output sclk, cs_n, din, mode, cfg, rst, broadcast_input0,
    input  dout
  );
  // device end
  modport dev (
    input  sclk, cs_n, din, mode, cfg, rst, broadcast_input0,
    output dout
  );
endinterface // csp_link_if

// [pkg/csp_pkg.sv]
// constants shared by both ends of the crosspoint programming link
// assumes: nothing beyond a SystemVerilog compiler
package csp_pkg;
  // ------------------------------------------------------------
  // matrix geometry
  // ------------------------------------------------------------
  localparam int NUM_OUT    = 8;
  localparam int SEL_W      = 4;
  localparam int SLOT_W     = 5;
  localparam int SLOT_OFF   = 4;
  localparam int FRAME_BITS = 40;
  localparam int WORD_BITS  = 8;
  localparam int CNT_W      = 6;

  // addressed word layout, bit 0 shifted first
  localparam int WA_LSB = 0;
  localparam int WA_W   = 3;
  localparam int WS_LSB = 3;
  localparam int WO_BIT = 7;

  localparam logic [CNT_W-1:0] WORD_LAST  = CNT_W'(WORD_BITS - 1);
  localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_BITS - 1);

  // ------------------------------------------------------------
  // override values
  // ------------------------------------------------------------
  localparam logic [SEL_W-1:0] RST_SEL = 4'h0;
  localparam logic             RST_OFF = 1'b1;
  localparam logic [SEL_W-1:0] BC_SEL  = 4'h0;
  localparam logic             BC_OFF  = 1'b0;

  // ------------------------------------------------------------
  // controller registers (byte offsets) and control bits
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DLO_OFS  = 8'h04;
  localparam logic [7:0] DHI_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] RX_OFS   = 8'h10;
  localparam int CB_START = 0;
  localparam int CB_MODE  = 1;
  localparam int CB_CFG   = 2;
  localparam int CB_RST   = 3;
  localparam int CB_BC    = 4;
  localparam int DHI_W    = FRAME_BITS - 32;

  // serial clock half period in pclk cycles
  localparam int HALF_DEF = 4;
endpackage

// [test/csp_asserts.sv]
// link checker for the crosspoint programming link
// assumes: controller with HALF of 4 and link signals wired in by the bench
`timescale 1ns/1ps
module csp_asserts import csp_pkg::*; (
  // clock and reset of the controller
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic mode,
  input wire logic cfg
);
  // ------------------------------------------------------------
  // helper: rising sclk edges inside one select window
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic             sclk_q;
  logic [CNT_W-1:0] rise_cnt;

  // count cleared while select is high, so each window starts at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q   <= 1'b0;
      rise_cnt <= '0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rise_cnt <= '0;
      end else if (sclk && !sclk_q) begin
        rise_cnt <= rise_cnt + CNT_W'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_sync;
    !sclk ##[1:8] sclk;
  endsequence
  sequence s_tail;
    !sclk ##[1:8] sclk ##[1:8] !sclk;
  endsequence

  a_first_rise: assert property ($fell(cs_n) |-> s_sync) else $error("no sync edge after select");
  a_tail_edge: assert property ($rose(cs_n) |-> s_tail) else $error("no closing sclk edge");
  a_cs_low_phase: assert property ($changed(cs_n) |-> !sclk && !$past(sclk)) else $error("select moved, sclk high");
  a_cfg_quiet: assert property (!cs_n |-> !cfg) else $error("cfg high while shifting");
  a_din_fall: assert property ($fell(sclk) && !cs_n |-> $stable(din)) else $error("din moved at sample edge");
  a_mode_hold: assert property (!cs_n && $past(!cs_n) |-> $stable(mode)) else $error("mode moved in window");
  a_cfg_pulse: assert property ($rose(cfg) |-> cfg[*4] ##1 !cfg) else $error("cfg pulse width wrong");
  a_bit_count: assert property ($rose(cs_n) |-> rise_cnt == (mode ? WORD_BITS : FRAME_BITS))
    else $error("wrong bit count in window");
endmodule // csp_asserts

// [test/test_crosspoint_serial_program_port.sv]
// testbench: controller and device joined by one link, a second device driven directly
// assumes: csp_pkg, csp_link_if, csp_ctrl, csp_device, csp_asserts compiled before
`timescale 1ns/1ps
module test_crosspoint_serial_program_port import csp_pkg::*;;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [FRAME_BITS-1:0] RST_FRAME = 40'h8421084210; // every slot select 0, off 1
  logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                    paddr;
  logic [31:0]                   pwdata, prdata;
  logic [NUM_OUT-1:0][SEL_W-1:0] sel_a, sel_b;
  logic [NUM_OUT-1:0]            off_a, off_b;
  logic [FRAME_BITS-1:0]         pend_a, pend_b, model;
  logic [33:0]                   exp_q[$];
  int                            err_count, check_count;

  csp_link_if link();
  csp_link_if link_b();
  csp_ctrl i_csp_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctrl));
  csp_device i_csp_device (.link(link.dev), .out_sel(sel_a), .out_off(off_a), .pend_frame(pend_a));
  csp_device i_csp_device_b (.link(link_b.dev), .out_sel(sel_b), .out_off(off_b), .pend_frame(pend_b));
  csp_asserts i_csp_asserts (.pclk(pclk), .presetn(presetn), .sclk(link.sclk), .cs_n(link.cs_n),
    .din(link.din), .mode(link.mode), .cfg(link.cfg));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    check_count++;
    if (seen !== expv) begin
      err_count++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // entered just after a rising edge; one spare edge after release keeps psel single-driven
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wd;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [32:0] e);
    logic [31:0] r;
    exp_q.push_back({1'b1, e});
    apb(1'b0, a, 32'h0, r);
  endtask

  // poll busy; notes with a clear top bit are skipped by the monitor
  task automatic wait_idle;
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 400) begin
      exp_q.push_back(34'h0);
      apb(1'b0, STAT_OFS, 32'h0, r);
      n++;
    end
    if (n >= 400) err_count++;
  endtask

  task automatic check_out(input logic [NUM_OUT-1:0][SEL_W-1:0] s, input logic [NUM_OUT-1:0] o,
                           input logic [FRAME_BITS-1:0] f);
    for (int i = 0; i < NUM_OUT; i++) begin
      check(s[i], f[SLOT_W*i +: SEL_W]);
      check(o[i], f[SLOT_W*i + SLOT_OFF]);
    end
  endtask

  // bench-made link clock, 125 ns period, inside the window plus one closing edge after select rises
  task automatic send_b(input logic [79:0] v, input int n, input logic m);
    link_b.mode = m;
    link_b.cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      link_b.sclk = 1'b1;
      link_b.din  = v[i];
      #62.5;
      link_b.sclk = 1'b0;
      if (i >= FRAME_BITS) check(link_b.dout, v[i-FRAME_BITS]);
      #62.5;
    end
    link_b.cs_n = 1'b1;
    link_b.din  = ~link_b.din;
    #62.5;
    link_b.sclk = 1'b1;
    #62.5;
    link_b.sclk = 1'b0;
    #62.5;
  endtask

  // ------------------------------------------------------------
  // clock, monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // oldest note is popped whenever a read answer appears, and compared only if its top bit is set
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      if (exp_q[0][33]) check({pslverr, prdata}, exp_q[0][32:0]);
      void'(exp_q.pop_front());
    end
  end

  initial begin
    #3000000;
    err_count++;
    conclude();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [79:0] v;
    logic [7:0]  w;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {link_b.sclk, link_b.din, link_b.mode, link_b.cfg, link_b.rst, link_b.broadcast_input0} = '0;
    link_b.cs_n = 1'b1;
    err_count   = 0;
    check_count = 0;
    void'($urandom(32'hca78dc36));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // level overrides with no link clock at all
    link_b.rst = 1'b1;
    #10;
    check_out(sel_b, off_b, RST_FRAME);
    link_b.broadcast_input0 = 1'b1;
    link_b.rst = 1'b0;
    #10;
    check_out(sel_b, off_b, 40'h0);
    link_b.broadcast_input0 = 1'b0;
    $display("test overrides done");
    @(posedge pclk);
    wr(CTRL_OFS, 32'h8);
    check_out(sel_a, off_a, RST_FRAME);
    wr(CTRL_OFS, 32'h0);
    rd_exp(CTRL_OFS, 33'h0);
    // full frame, held pending until a separate strobe
    model = 40'({$urandom(), $urandom()});
    wr(DLO_OFS, model[31:0]);
    wr(DHI_OFS, {24'h0, model[39:32]});
    rd_exp(DHI_OFS, {1'b0, 24'h0, model[39:32]});
    wr(CTRL_OFS, 32'h1);
    rd_exp(STAT_OFS, 33'h1);
    wait_idle();
    check(pend_a, model);
    check_out(sel_a, off_a, RST_FRAME);
    wr(CTRL_OFS, 32'h4);
    wait_idle();
    check_out(sel_a, off_a, model);
    wr(CTRL_OFS, 32'h10);
    check_out(sel_a, off_a, 40'h0);
    wr(CTRL_OFS, 32'h0);
    wr(CTRL_OFS, 32'h4);
    wait_idle();
    check_out(sel_a, off_a, 40'h0);
    rd_exp(8'h20, {1'b1, 32'h0});
    $display("test full frame done");
    // addressed words, every output once, highest first
    for (int i = 0; i < NUM_OUT; i++) begin
      w = 8'($urandom());
      w[WA_LSB +: WA_W] = 3'(NUM_OUT - 1 - i);
      model[SLOT_W*(NUM_OUT-1-i) +: SLOT_W] = w[WO_BIT:WS_LSB];
      wr(DLO_OFS, {24'h0, w});
      wr(CTRL_OFS, 32'h7);
      wait_idle();
      check(pend_a, model);
      check_out(sel_a, off_a, model);
    end
    rd_exp(CTRL_OFS, 33'h6);
    $display("test addressed done");
    // double length stream: dout carries the first frame on
    v = 80'({$urandom(), $urandom(), $urandom()});
    send_b(v, 80, 1'b0);
    check(pend_b, v[79:40]);
    check_out(sel_b, off_b, 40'h0);
    link_b.cfg = 1'b1;
    #62.5;
    link_b.cfg = 1'b0;
    #62.5;
    check_out(sel_b, off_b, v[79:40]);
    // clock and data toggled with select high
    for (int i = 0; i < 12; i++) begin
      link_b.din  = 1'($urandom());
      link_b.sclk = 1'b1;
      #62.5;
      link_b.sclk = 1'b0;
      #62.5;
    end
    check(pend_b, v[79:40]);
    $display("test chain done");
    conclude();
  end
endmodule // test_crosspoint_serial_program_port
